//--- logic/pcls_regs.svh
// timing counts and field constants for the configuration load host
// assumes a 100 MHz system clock
`ifndef PCLS_REGS_SVH
`define PCLS_REGS_SVH
`define PCLS_CLK_NS 10
`define PCLS_CFG_LOW_US 2
`define PCLS_CFG_LOW_CYC ((`PCLS_CFG_LOW_US * 1000 + `PCLS_CLK_NS - 1) / `PCLS_CLK_NS)
`define PCLS_ST2CK_US 2
`define PCLS_ST2CK_CYC ((`PCLS_ST2CK_US * 1000 + `PCLS_CLK_NS - 1) / `PCLS_CLK_NS)
`define PCLS_CF2CK_US 1506
`define PCLS_CF2CK_CYC ((`PCLS_CF2CK_US * 1000 + `PCLS_CLK_NS - 1) / `PCLS_CLK_NS)
`define PCLS_DONE_WAIT_US 1506
`define PCLS_DONE_WAIT_CYC ((`PCLS_DONE_WAIT_US * 1000) / `PCLS_CLK_NS)
`define PCLS_HALF_PERIOD 4
`define PCLS_END_FALLS 2
`define PCLS_R_PLAIN 1
`define PCLS_R_SECURE 4
`define PCLS_R_COMPRESS 8
`endif

//--- logic/pcls_pkg.sv
// types for the configuration load host
// assumes pcls_regs.svh supplies the numeric constants
package pcls_pkg;
  typedef enum logic [3:0] {
    PCLS_IDLE, PCLS_REQ_LOW, PCLS_WAIT_OK, PCLS_OK_GAP, PCLS_WAIT_WORD,
    PCLS_CLK_HI, PCLS_CLK_LO, PCLS_TAIL, PCLS_END_EDGES, PCLS_DONE, PCLS_FAIL
  } pcls_state_t;
endpackage : pcls_pkg

//--- logic/pcls_host.sv
// host sequencer that loads a configuration image into a parallel-load device
// assumes device pins are asynchronous; words come from a same-clock source
`timescale 1ns/10ps
`include "pcls_regs.svh"
module pcls_host (
  input  wire logic                sys_clk,
  input  wire logic                resetn,
  input  wire logic                start,
  input  wire logic                use_compress,
  input  wire logic                use_secure,
  input  wire logic                watch_status,
  input  wire logic [31:0]         word_data,
  input  wire logic                word_valid,
  input  wire logic                word_last,
  output logic                     word_ready,
  output logic                     busy,
  output logic                     done,
  output logic                     error,
  output logic                     config_request_n,
  input  wire logic                load_ok_n_in,
  input  wire logic                load_complete_in,
  output logic                     load_clock,
  output logic [31:0]              load_data
);
  import pcls_pkg::*;

  pcls_state_t state_r;
  logic [2:0]  ok_sync_r;
  logic [2:0]  cd_sync_r;
  logic        ok_r;
  logic        cd_r;
  logic [19:0] cnt_r;
  logic [3:0]  ratio_r;
  logic [3:0]  edge_r;
  logic        last_r;
  logic [1:0]  falls_r;
  logic [7:0]  req_low_cnt_r;
  logic [7:0]  ok_hi_cnt_r;

  // ratio from feature settings
  function automatic logic [3:0] pcls_ratio(input logic comp, input logic sec);
    if (comp) begin
      pcls_ratio = 4'(`PCLS_R_COMPRESS);
    end else if (sec) begin
      pcls_ratio = 4'(`PCLS_R_SECURE);
    end else begin
      pcls_ratio = 4'(`PCLS_R_PLAIN);
    end
  endfunction : pcls_ratio

  // three-stage sampling of device pins, change accepted when last two agree
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ok_sync_r <= 3'h0;
      cd_sync_r <= 3'h0;
      ok_r      <= 1'b0;
      cd_r      <= 1'b0;
    end else begin
      ok_sync_r <= {ok_sync_r[1:0], load_ok_n_in};
      cd_sync_r <= {cd_sync_r[1:0], load_complete_in};
      if (ok_sync_r[1] == ok_sync_r[2]) begin
        ok_r <= ok_sync_r[2];
      end
      if (cd_sync_r[1] == cd_sync_r[2]) begin
        cd_r <= cd_sync_r[2];
      end
    end
  end

  // main sequencer
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_r          <= PCLS_IDLE;
      cnt_r            <= 20'h0;
      ratio_r          <= 4'h1;
      edge_r           <= 4'h0;
      last_r           <= 1'b0;
      falls_r          <= 2'h0;
      config_request_n <= 1'b1;
      load_clock       <= 1'b0;
      load_data        <= 32'h0;
      word_ready       <= 1'b0;
      busy             <= 1'b0;
      done             <= 1'b0;
      error            <= 1'b0;
    end else begin
      word_ready <= 1'b0;
      case (state_r)
        PCLS_IDLE: begin
          load_clock <= 1'b0;
          if (start) begin
            config_request_n <= 1'b0;
            ratio_r          <= pcls_ratio(use_compress, use_secure);
            cnt_r            <= 20'h0;
            busy             <= 1'b1;
            done             <= 1'b0;
            error            <= 1'b0;
            state_r          <= PCLS_REQ_LOW;
          end
        end
        PCLS_REQ_LOW: begin
          cnt_r <= cnt_r + 20'h1;
          if (cnt_r >= 20'(`PCLS_CFG_LOW_CYC - 1)) begin
            config_request_n <= 1'b1;
            cnt_r            <= 20'h0;
            state_r          <= PCLS_WAIT_OK;
          end
        end
        PCLS_WAIT_OK: begin
          cnt_r <= cnt_r + 20'h1;
          if (watch_status && ok_r && cnt_r > 20'h4) begin
            cnt_r   <= 20'h0;
            state_r <= PCLS_OK_GAP;
          end else if (!watch_status && cnt_r >= 20'(`PCLS_CF2CK_CYC - 1)) begin
            cnt_r   <= 20'h0;
            state_r <= PCLS_WAIT_WORD;
          end else if (watch_status && cnt_r >= 20'(`PCLS_DONE_WAIT_CYC * 2)) begin
            error   <= 1'b1;
            state_r <= PCLS_FAIL;
          end
        end
        PCLS_OK_GAP: begin
          cnt_r <= cnt_r + 20'h1;
          if (cnt_r >= 20'(`PCLS_ST2CK_CYC - 1)) begin
            state_r <= PCLS_WAIT_WORD;
          end
        end
        PCLS_WAIT_WORD: begin
          load_clock <= 1'b0;
          if (word_valid) begin
            load_data  <= word_data;
            last_r     <= word_last;
            word_ready <= 1'b1;
            edge_r     <= 4'h0;
            cnt_r      <= 20'h0;
            state_r    <= PCLS_CLK_LO;
          end
        end
        PCLS_CLK_LO: begin
          cnt_r <= cnt_r + 20'h1;
          if (cnt_r >= 20'(`PCLS_HALF_PERIOD - 1)) begin
            load_clock <= 1'b1;
            cnt_r      <= 20'h0;
            edge_r     <= edge_r + 4'h1;
            state_r    <= PCLS_CLK_HI;
          end
        end
        PCLS_CLK_HI: begin
          cnt_r <= cnt_r + 20'h1;
          if (cnt_r >= 20'(`PCLS_HALF_PERIOD - 1)) begin
            load_clock <= 1'b0;
            cnt_r      <= 20'h0;
            if (edge_r < ratio_r) begin
              state_r <= PCLS_CLK_LO;
            end else if (last_r) begin
              falls_r <= 2'h0;
              state_r <= PCLS_TAIL;
            end else begin
              state_r <= PCLS_WAIT_WORD;
            end
          end
        end
        PCLS_TAIL: begin
          cnt_r <= cnt_r + 20'h1;
          if (cd_r) begin
            cnt_r   <= 20'h0;
            state_r <= PCLS_END_EDGES;
          end else if (cnt_r >= 20'(`PCLS_DONE_WAIT_CYC)) begin
            error   <= 1'b1;
            state_r <= PCLS_FAIL;
          end
        end
        PCLS_END_EDGES: begin
          cnt_r <= cnt_r + 20'h1;
          if (cnt_r >= 20'(`PCLS_HALF_PERIOD - 1)) begin
            cnt_r      <= 20'h0;
            load_clock <= !load_clock;
            if (load_clock) begin
              falls_r <= falls_r + 2'h1;
              if (falls_r == 2'(`PCLS_END_FALLS - 1)) begin
                state_r <= PCLS_DONE;
              end
            end
          end
        end
        PCLS_DONE: begin
          load_clock <= 1'b0;
          busy       <= 1'b0;
          done       <= 1'b1;
          state_r    <= PCLS_IDLE;
        end
        PCLS_FAIL: begin
          load_clock <= 1'b0;
          busy       <= 1'b0;
          state_r    <= PCLS_IDLE;
        end
        default: begin
          state_r <= PCLS_IDLE;
        end
      endcase
    end
  end

  // cycles the request has been low, saturating, for the width check
  always_ff @(posedge sys_clk) begin
    if (!resetn || config_request_n) begin
      req_low_cnt_r <= 8'h0;
    end else if (req_low_cnt_r != 8'hff) begin
      req_low_cnt_r <= req_low_cnt_r + 8'h1;
    end
  end

  // cycles since status was seen high, saturating, for the start gap check
  always_ff @(posedge sys_clk) begin
    if (!resetn || !ok_r) begin
      ok_hi_cnt_r <= 8'h0;
    end else if (ok_hi_cnt_r != 8'hff) begin
      ok_hi_cnt_r <= ok_hi_cnt_r + 8'h1;
    end
  end

  // request pulse long enough
  a_req_low_width: assert property (@(posedge sys_clk) disable iff (!resetn)
    $fell(config_request_n) |-> !config_request_n [*8])
    else $error("request pulse too short");

  // data stable while clock high
  a_data_stable_hi: assert property (@(posedge sys_clk) disable iff (!resetn)
    load_clock && $past(load_clock) |-> $stable(load_data))
    else $error("data changed while clock high");

  // new data only while clock low
  a_data_on_low: assert property (@(posedge sys_clk) disable iff (!resetn)
    !$stable(load_data) |-> !load_clock)
    else $error("data changed with clock high");

  // clock parked low outside a load
  a_clk_parked: assert property (@(posedge sys_clk) disable iff (!resetn)
    state_r == PCLS_IDLE |=> !load_clock)
    else $error("load clock not parked");

  // rises never exceed ratio per word
  a_ratio_bound: assert property (@(posedge sys_clk) disable iff (!resetn)
    state_r == PCLS_CLK_HI |-> edge_r <= ratio_r && edge_r != 4'h0)
    else $error("word edge count out of range");

  // ratio encoding
  a_ratio_code: assert property (@(posedge sys_clk) disable iff (!resetn)
    ratio_r == 4'h1 || ratio_r == 4'h4 || ratio_r == 4'h8)
    else $error("illegal ratio");

  // finishing needs completion seen
  a_done_after_cd: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(done) |-> $past(state_r) == PCLS_DONE)
    else $error("done without end edges");

  // clock low in gap before first word
  a_gap_clock_low: assert property (@(posedge sys_clk) disable iff (!resetn)
    state_r == PCLS_OK_GAP || state_r == PCLS_WAIT_OK |-> !load_clock)
    else $error("clock edge before start gap");

  // request pulse held for its full width
  a_req_low_count: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(config_request_n) |-> req_low_cnt_r >= 8'(`PCLS_CFG_LOW_CYC))
    else $error("request pulse shorter than its minimum");

  // clock rises keep their distance from status going high
  a_status_gap: assert property (@(posedge sys_clk) disable iff (!resetn)
    watch_status && $rose(load_clock) |-> ok_hi_cnt_r >= 8'(`PCLS_ST2CK_CYC))
    else $error("clock rise too soon after status");

  // word taken at most once per pulse
  a_ready_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
    word_ready |=> !word_ready)
    else $error("word ready held longer than one cycle");

  // busy and done never overlap
  a_busy_done: assert property (@(posedge sys_clk) disable iff (!resetn)
    !(busy && done))
    else $error("busy and done together");

  // completion follows exactly the two end falls
  a_end_falls: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(done) |-> falls_r == 2'(`PCLS_END_FALLS))
    else $error("done without two end falls");
endmodule : pcls_host

//--- sim/pcls_dev_model.sv
// behavioural parallel-load device facing the host's pins
// assumes the bench sets ratio and n_words before each load
`timescale 1ns/10ps
module pcls_dev_model (
  input  wire logic        config_request_n,
  input  wire logic        load_clock,
  input  wire logic [31:0] load_data,
  output logic             load_ok_n,
  output logic             load_complete
);
  int          ratio;
  int          n_words;
  int          edge_cnt;
  int          n_falls;
  int          errs;
  logic [31:0] got[$];
  realtime     t_low;
  realtime     t_ok;
  bit          req_seen;
  bit          fin;
  logic        init_done_n;
  // power-up: status and completion held low
  initial begin
    load_ok_n = 1'b0;
    load_complete = 1'b0;
    init_done_n = 1'b1;
    errs = 0;
  end
  // request low restarts, both lines drop well inside 600 ns
  always @(negedge config_request_n) begin
    t_low = $realtime;
    req_seen = 1'b1;
    #100 load_ok_n = 1'b0;
    load_complete = 1'b0;
    edge_cnt = 0;
    n_falls = 0;
    got.delete();
    fin = 1'b0;
  end
  // short request pulses flagged; status low for its minimum pulse
  // the rise out of the unknown power-up value is not a request
  always @(posedge config_request_n) begin
    if (req_seen) begin
      if ($realtime - t_low < 2000) errs++;
      #268000 load_ok_n = 1'b1;
      t_ok = $realtime;
    end
  end
  // capture on the first rise of each group, complete r-1 rises later
  always @(posedge load_clock) begin
    if (load_ok_n !== 1'b1 || $realtime - t_ok < 2000) errs++;
    if (got.size() < n_words && edge_cnt % ratio == 0) got.push_back(load_data);
    edge_cnt++;
    if (got.size() == n_words && edge_cnt == n_words * ratio) fin = 1'b1;
  end
  // completion after the fall closing the last group; later falls start initialization
  always @(negedge load_clock) begin
    if (load_complete) begin
      n_falls++;
      if (n_falls == 2) init_done_n <= #175000 1'b1;
    end else if (fin) begin
      load_complete <= #30 1'b1;
      init_done_n <= #30 1'b0;
    end
  end
endmodule : pcls_dev_model

//--- sim/tb_top.sv
// self-checking bench: host sequencer against the behavioural device
// assumes the full 1506 us counts, so the no-watch mode is only run partway
`timescale 1ns/10ps
`include "pcls_regs.svh"
module tb_top;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        start = 1'b0;
  logic        use_compress = 1'b0;
  logic        use_secure = 1'b0;
  logic        watch_status = 1'b1;
  logic        word_valid = 1'b0;
  logic        word_last = 1'b0;
  logic [31:0] word_data = 32'h0;
  logic [31:0] load_data;
  logic        word_ready, busy, done, error, config_request_n;
  logic        load_ok_n, load_complete, load_clock;
  int          miscompares = 0;
  int          n_checks = 0;
  logic [31:0] exp_q[$];
  always #5 sys_clk = ~sys_clk;
  pcls_host i_pcls_host (.sys_clk(sys_clk), .resetn(resetn), .start(start),
    .use_compress(use_compress), .use_secure(use_secure), .watch_status(watch_status),
    .word_data(word_data), .word_valid(word_valid), .word_last(word_last),
    .word_ready(word_ready), .busy(busy), .done(done), .error(error),
    .config_request_n(config_request_n), .load_ok_n_in(load_ok_n),
    .load_complete_in(load_complete), .load_clock(load_clock), .load_data(load_data));
  pcls_dev_model i_pcls_dev_model (.config_request_n(config_request_n),
    .load_clock(load_clock), .load_data(load_data), .load_ok_n(load_ok_n),
    .load_complete(load_complete));
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    n_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("mismatch at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask : check
  task automatic give_verdict();
    if (miscompares == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  function automatic int exp_ratio(input logic c, input logic s);
    return c ? `PCLS_R_COMPRESS : (s ? `PCLS_R_SECURE : `PCLS_R_PLAIN);
  endfunction : exp_ratio
  // one whole image load with random gaps between words
  task automatic load(input logic c, input logic s, input int n);
    int k;
    int gap;
    i_pcls_dev_model.ratio = exp_ratio(c, s);
    i_pcls_dev_model.n_words = n;
    exp_q.delete();
    @(negedge sys_clk);
    use_compress = c;
    use_secure = s;
    start = 1'b1;
    repeat (2) @(negedge sys_clk);
    check(config_request_n, 1'b0, "request");
    check(busy, 1'b1, "busy");
    start = 1'b0;
    for (int i = 0; i < n; i++) begin
      word_data = (i == 0) ? 32'hffffffff : $urandom;
      exp_q.push_back(word_data);
      word_valid = 1'b1;
      word_last = (i == n - 1);
      k = 0;
      while (word_ready !== 1'b1 && k < 40000) begin
        @(negedge sys_clk);
        k++;
      end
      check(word_ready, 1'b1, "word taken");
      @(negedge sys_clk);
      gap = ($urandom % 3 == 0) ? 1 + $urandom % 10 : 0;
      if (gap > 0) begin
        word_valid = 1'b0; // clock finishes the taken word first, and parks low only if the gap outlasts it
        repeat (gap) @(negedge sys_clk);
      end
    end
    word_valid = 1'b0;
    word_last = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 2000) begin
      @(negedge sys_clk);
      k++;
    end
    check(done, 1'b1, "done");
    check(error, 1'b0, "error");
    check(busy, 1'b0, "busy after");
    check(load_clock, 1'b0, "clock parked");
    check(i_pcls_dev_model.n_falls, 2, "end falls");
    check(i_pcls_dev_model.init_done_n, 1'b0, "init pending");
    check(i_pcls_dev_model.errs, 0, "device errors");
    check(i_pcls_dev_model.got.size(), n, "word count");
    for (int i = 0; i < n; i++) check(i_pcls_dev_model.got[i], exp_q[i], "word");
  endtask : load
  // main sequence: the three ratios, a no-watch start, then a reset in mid-load
  initial begin
    void'($urandom(80855));
    repeat (3) @(negedge sys_clk);
    resetn = 1'b1;
    load(1'b0, 1'b0, 2 + $urandom % 4);
    load(1'b0, 1'b1, 2 + $urandom % 4);
    load(1'b1, 1'($urandom), 2 + $urandom % 3);
    // no-watch mode: still no clock 1000 cycles in, long before the 1506 us wait ends
    watch_status = 1'b0;
    start = 1'b1;
    @(negedge sys_clk);
    start = 1'b0;
    word_valid = 1'b1;
    repeat (1000) @(negedge sys_clk);
    check(load_clock, 1'b0, "clock before 1506 us");
    check(busy, 1'b1, "still waiting");
    check(error, 1'b0, "no timeout yet");
    check(i_pcls_dev_model.got.size(), 0, "words before 1506 us");
    check(i_pcls_dev_model.errs, 0, "device errors");
    // reset in mid-load, then release
    resetn = 1'b0;
    @(negedge sys_clk);
    check(done, 1'b0, "done in reset");
    check(config_request_n, 1'b1, "request in reset");
    word_valid = 1'b0;
    resetn = 1'b1;
    repeat (2) @(negedge sys_clk);
    check(busy, 1'b0, "busy after reset");
    check(load_clock, 1'b0, "clock after reset");
    check(config_request_n, 1'b1, "request after reset");
    give_verdict();
  end
  // watchdog cuts a hang short
  initial begin
    #950000;
    miscompares++;
    give_verdict();
  end
endmodule : tb_top
